// ---- dv/host_bus_model.sv ----
// Host bus master model driving the acknowledge and select pins
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
(
    input wire logic clk, // Block clock
    input wire logic tack_oe, // Transfer ack pulled low
    input wire logic data_oe, // Vector byte driven
    input wire logic [7:0] data, // Vector byte
    output logic cs_n, // Host select
    output logic strobe_n, // Read or data strobe
    output logic write_n, // Write strobe
    output logic fetch_n, // Interrupt acknowledge
    output logic dack_a_n, // DMA acknowledge A
    output logic dack_b_n // DMA acknowledge B
);
    // Idle bus; DMA acks never used, select kept off in fetches
    initial
    begin
        cs_n = 1'b1;
        strobe_n = 1'b1;
        write_n = 1'b1;
        fetch_n = 1'b1;
        dack_a_n = 1'b1;
        dack_b_n = 1'b1;
    end

    // One acknowledge or register cycle, held until ack or bound runs out
    task automatic bus_cycle(input logic is_fetch, input logic use_strobe, output logic ok, output logic [7:0] vec);
        int n;
        ok = 1'b0;
        vec = 8'h00;
        @(posedge clk);
        fetch_n <= !is_fetch;
        cs_n <= is_fetch;
        strobe_n <= !use_strobe;
        // Answer taken at the rising edge that shows the ack, released at that same edge
        for (n = 0; n < 10 && !ok; n++)
        begin
            @(posedge clk);
            if (tack_oe === 1'b1)
            begin
                ok = 1'b1;
                vec = (data_oe === 1'b1) ? data : 8'h00;
            end
        end
        fetch_n <= 1'b1;
        cs_n <= 1'b1;
        strobe_n <= 1'b1;
    endtask
endmodule // host_bus_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking testbench for the request and acknowledge block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic MCLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [7:0] PADDR, CH_EVENT_LOW, CH_EVENT_HIGH, PP_EVENT, DATA_O;
    logic [31:0] PWDATA, PRDATA, rd;
    logic cs_n, strobe_n, write_n, fetch_n, dack_a_n, dack_b_n, chain_in, addr0, chain_wire;
    logic chain_o, chain_oe, req_o, req_oe, tack_n, tack_oe, DATA_OE, er, ok;
    logic [7:0] vec;
    int err_total, total_checks;

    // Chain pin level: the block drives it in daisy mode, else the bench
    assign chain_wire = chain_oe ? chain_o : addr0;

    irq_ack_ctrl u_dut (.MCLK(MCLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .CH_EVENT_LOW(CH_EVENT_LOW), .CH_EVENT_HIGH(CH_EVENT_HIGH), .PP_EVENT(PP_EVENT),
        .CHIP_SELECT_N(cs_n), .BUS_STROBE_N(strobe_n), .WRITE_N(write_n), .VECTOR_FETCH_STROBE_N(fetch_n),
        .DMA_ACK_CHAN_A_N(dack_a_n), .DMA_ACK_CHAN_B_N(dack_b_n), .CHAIN_ENABLE_IN(chain_in),
        .CHAIN_ENABLE_OUT_I(chain_wire), .CHAIN_ENABLE_OUT_O(chain_o), .CHAIN_ENABLE_OUT_OE(chain_oe),
        .SERVICE_REQ_O(req_o), .SERVICE_REQ_OE(req_oe), .TRANSFER_ACK_OUT_N(tack_n),
        .TRANSFER_ACK_OUT_OE(tack_oe), .DATA_O(DATA_O), .DATA_OE(DATA_OE));

    host_bus_model u_host (.clk(MCLK), .tack_oe(tack_oe), .data_oe(DATA_OE), .data(DATA_O), .cs_n(cs_n),
        .strobe_n(strobe_n), .write_n(write_n), .fetch_n(fetch_n), .dack_a_n(dack_a_n), .dack_b_n(dack_b_n));

    // Free-running clock, 10 ns period
    initial
    begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // APB transfer held until PREADY, bounded wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge MCLK);
            if (PREADY === 1'b1)
                break;
        end
        if (n == 16)
        begin
            err_total++;
            wrap_up();
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // Let requests and service updates land, then sample mid-cycle
    task automatic settle;
        repeat (4) @(posedge MCLK);
        @(negedge MCLK);
    endtask

    task automatic pulse(input logic [23:0] src);
        @(posedge MCLK);
        {PP_EVENT, CH_EVENT_HIGH, CH_EVENT_LOW} <= src;
        @(posedge MCLK);
        {PP_EVENT, CH_EVENT_HIGH, CH_EVENT_LOW} <= 24'h000000;
        settle();
    endtask

    task automatic fetch(input logic use_strobe);
        u_host.bus_cycle(1'b1, use_strobe, ok, vec);
        settle();
    endtask

    // Reset values, unmapped access, masked source, unmask, clear
    task automatic t_regs;
        apb(1'b0, irq_ack_pkg::MASK_OFFSET, 32'h0);
        chk(rd, 32'h00FFFFFF);
        apb(1'b0, 8'h18, 32'h0);
        chk(er, 1'b1);
        chk(req_o, 1'b1);
        chk(chain_oe, 1'b0);
        chk(tack_n, 1'b0);
        pulse(24'h000004);
        chk(req_o, 1'b1);
        apb(1'b0, irq_ack_pkg::CAUSE_LOW_OFFSET, 32'h0);
        chk(rd[7:0], 8'h04);
        apb(1'b1, irq_ack_pkg::MASK_OFFSET, 32'h0);
        settle();
        chk(req_o, 1'b0);
        apb(1'b0, irq_ack_pkg::SUMMARY_OFFSET, 32'h0);
        chk(rd[3:0], 4'h9);
        apb(1'b1, irq_ack_pkg::CAUSE_LOW_OFFSET, 32'hFF);
        settle();
        chk(req_o, 1'b1);
    endtask

    // Every pin style while a request is active, then idle open drain
    task automatic t_style;
        logic [1:0] s;
        pulse(24'h000001);
        for (int i = 0; i < 3; i++)
        begin
            s = 2'(i);
            apb(1'b1, irq_ack_pkg::CONFIG_OFFSET, {28'h0, s, 2'h0});
            @(negedge MCLK);
            chk({req_oe, req_o}, (s == 2'h1) ? 2'h3 : 2'h2);
        end
        apb(1'b1, irq_ack_pkg::CAUSE_LOW_OFFSET, 32'hFF);
        settle();
        chk(req_oe, 1'b0);
    endtask

    // Each group alone, then two groups pending at once
    task automatic t_prio;
        apb(1'b1, irq_ack_pkg::CONFIG_OFFSET, 32'h0000A840);
        for (int g = 0; g < 8; g++)
        begin
            pulse(24'h1 << (3 * g));
            fetch(1'b1);
            chk(ok, 1'b1);
            chk(vec, 8'hA8 | 8'(g));
            chk(req_o, 1'b1);
        end
        pulse(24'h100020);
        fetch(1'b1);
        chk(vec, 8'hA9);
        chk(req_o, 1'b0);
        chk({tack_oe, DATA_OE}, 2'h0);
        fetch(1'b1);
        chk(vec, 8'hAE);
        chk(req_o, 1'b1);
    endtask

    // Two-cycle style: request stays after first, drops after second
    task automatic t_two;
        apb(1'b1, irq_ack_pkg::CONFIG_OFFSET, 32'h1);
        pulse(24'h000200);
        fetch(1'b0);
        chk(ok, 1'b1);
        chk(req_o, 1'b0);
        fetch(1'b0);
        chk(vec, 8'h03);
        chk(req_o, 1'b1);
        u_host.bus_cycle(1'b0, 1'b1, ok, vec);
        chk(ok, 1'b1);
        @(negedge MCLK);
        chk(tack_oe, 1'b0);
    endtask

    // Slave address two: refused on mismatch, taken on match
    task automatic t_slave;
        apb(1'b1, irq_ack_pkg::CONFIG_OFFSET, 32'h20);
        pulse(24'h000001);
        fetch(1'b1);
        chk(ok, 1'b0);
        chk(req_o, 1'b0);
        @(posedge MCLK) chain_in <= 1'b1;
        fetch(1'b1);
        chk(ok, 1'b1);
        chk(req_o, 1'b1);
        @(posedge MCLK) chain_in <= 1'b0;
    endtask

    // Daisy chain: gating by chain-in, chain-out follows own request
    task automatic t_daisy;
        apb(1'b1, irq_ack_pkg::CONFIG_OFFSET, 32'h2);
        pulse(24'h000001);
        chk(req_o, 1'b1);
        chk(chain_o, 1'b0);
        chk(chain_oe, 1'b1);
        @(posedge MCLK) chain_in <= 1'b1;
        settle();
        chk({req_o, chain_o}, 2'h0);
        @(posedge MCLK) chain_in <= 1'b0;
        settle();
        chk(req_o, 1'b1);
        @(posedge MCLK) chain_in <= 1'b1;
        settle();
        fetch(1'b1);
        chk(ok, 1'b1);
        chk({req_o, chain_o}, 2'h3);
    endtask

    initial
    begin
        ARST_N = 1'b0;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {PP_EVENT, CH_EVENT_HIGH, CH_EVENT_LOW} = '0;
        chain_in = 1'b0;
        addr0 = 1'b0;
        err_total = 0;
        total_checks = 0;
        repeat (4) @(posedge MCLK);
        ARST_N <= 1'b1;
        t_regs();
        t_style();
        t_prio();
        t_two();
        t_slave();
        t_daisy();
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire

// ---- logic/cause_bank.sv ----
// One bank of sticky interrupt cause bits with write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module cause_bank
(
    input wire logic clk, // Block clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [irq_ack_pkg::BANK_W-1:0] set_in, // Event pulses
    input wire logic [irq_ack_pkg::BANK_W-1:0] clear_in, // Clear strobes
    output logic [irq_ack_pkg::BANK_W-1:0] cause_out // Sticky cause bits
);

    logic [irq_ack_pkg::BANK_W-1:0] cause_reg;
    logic [irq_ack_pkg::BANK_W-1:0] cause_next;

    // Set wins over clear so an event in the clearing cycle survives
    always_comb
    begin
        cause_next = (cause_reg & ~clear_in) | set_in;
    end

    // Register stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cause_reg <= '0;
        else
            cause_reg <= cause_next;
    end

    assign cause_out = cause_reg;

endmodule // cause_bank
`default_nettype wire

// ---- logic/irq_ack_ctrl.sv ----
// Interrupt request merge, acknowledge vector and transfer acknowledge logic
`timescale 1ns/1ps
`default_nettype none
module irq_ack_ctrl
(
    input wire logic MCLK, // Block clock
    input wire logic ARST_N, // Asynchronous reset, active low
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB direction
    input wire logic [7:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error on unmapped address
    input wire logic [7:0] CH_EVENT_LOW, // Channel event pulses, low bank
    input wire logic [7:0] CH_EVENT_HIGH, // Channel event pulses, high bank
    input wire logic [7:0] PP_EVENT, // Parallel port event pulses
    input wire logic CHIP_SELECT_N, // Host select
    input wire logic BUS_STROBE_N, // Read or data strobe
    input wire logic WRITE_N, // Write strobe or direction
    input wire logic VECTOR_FETCH_STROBE_N, // Interrupt acknowledge
    input wire logic DMA_ACK_CHAN_A_N, // DMA acknowledge A
    input wire logic DMA_ACK_CHAN_B_N, // DMA acknowledge B
    input wire logic CHAIN_ENABLE_IN, // Chain enable in, address bit 1
    input wire logic CHAIN_ENABLE_OUT_I, // Chain pin level, address bit 0
    output logic CHAIN_ENABLE_OUT_O, // Chain enable out level
    output logic CHAIN_ENABLE_OUT_OE, // Chain pin driven
    output logic SERVICE_REQ_O, // Request pin level
    output logic SERVICE_REQ_OE, // Request pin driven
    output logic TRANSFER_ACK_OUT_N, // Transfer ack level, always low
    output logic TRANSFER_ACK_OUT_OE, // Transfer ack driven low
    output logic [7:0] DATA_O, // Vector byte
    output logic DATA_OE // Vector byte driven
);

    logic [31:0] config_reg, config_next;
    logic [31:0] mask_reg, mask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic req_reg, req_next;
    logic tack_reg, tack_next;
    logic fetch_prev_reg, fetch_prev_next;
    logic [7:0] vec_reg, vec_next;
    logic [2:0] grp_reg, grp_next;
    irq_ack_pkg::ack_state_t state_reg, state_next;
    logic [7:0] cause_low, cause_high, cause_pp;
    logic [7:0] clr_low, clr_high, clr_pp;
    logic [23:0] pend, pend_after, grp_clr_mask;
    logic [7:0] grp_active;
    logic [2:0] win_idx;
    logic any_pend, two_cycle, daisy, pp_en, wr_en, rd_setup, addr_ok;
    logic ack_active, ack_rise, ack_fall, addr_match, accept_ok, complete, holdoff;
    logic reg_cycle, tack_cond, in_service;
    logic [1:0] slave_addr;
    irq_ack_pkg::port_style_t port_style;

    // Configuration fields
    assign two_cycle = config_reg[irq_ack_pkg::CFG_BUS_STYLE_BIT];
    assign daisy = config_reg[irq_ack_pkg::CFG_DAISY_BIT];
    assign pp_en = config_reg[irq_ack_pkg::CFG_PP_EN_BIT];
    assign port_style = irq_ack_pkg::port_style_t'(config_reg[irq_ack_pkg::CFG_PORT_LSB +: 2]);
    assign slave_addr = config_reg[irq_ack_pkg::CFG_SLAVE_LSB +: 2];

    // APB decode, no wait state; read data is captured into a flop in the setup phase
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    assign addr_ok = (PADDR == irq_ack_pkg::CONFIG_OFFSET) || (PADDR == irq_ack_pkg::MASK_OFFSET) ||
        (PADDR == irq_ack_pkg::CAUSE_LOW_OFFSET) || (PADDR == irq_ack_pkg::CAUSE_HIGH_OFFSET) ||
        (PADDR == irq_ack_pkg::PP_CAUSE_OFFSET) || (PADDR == irq_ack_pkg::SUMMARY_OFFSET);
    assign PREADY = PSEL && PENABLE;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;
    assign PRDATA = prdata_reg;

    // Cause banks: channel events always record, parallel port events only with pp_en; masks only gate the request
    cause_bank u_cause_low (.clk(MCLK), .rst_n(ARST_N), .set_in(CH_EVENT_LOW),
        .clear_in(clr_low), .cause_out(cause_low));
    cause_bank u_cause_high (.clk(MCLK), .rst_n(ARST_N), .set_in(CH_EVENT_HIGH),
        .clear_in(clr_high), .cause_out(cause_high));
    cause_bank u_cause_pp (.clk(MCLK), .rst_n(ARST_N), .set_in(PP_EVENT & {irq_ack_pkg::BANK_W{pp_en}}),
        .clear_in(clr_pp), .cause_out(cause_pp));

    // Software write-one-to-clear plus clear of the serviced group
    always_comb
    begin
        clr_low = grp_clr_mask[7:0];
        clr_high = grp_clr_mask[15:8];
        clr_pp = grp_clr_mask[23:16];
        if (wr_en && PADDR == irq_ack_pkg::CAUSE_LOW_OFFSET)
            clr_low = clr_low | PWDATA[7:0];
        if (wr_en && PADDR == irq_ack_pkg::CAUSE_HIGH_OFFSET)
            clr_high = clr_high | PWDATA[7:0];
        if (wr_en && PADDR == irq_ack_pkg::PP_CAUSE_OFFSET)
            clr_pp = clr_pp | PWDATA[7:0];
    end

    // Masked pending sources and fixed-priority groups, group 0 highest
    always_comb
    begin
        pend = {cause_pp & ~mask_reg[irq_ack_pkg::MASK_PP_LSB +: 8],
            cause_high & ~mask_reg[irq_ack_pkg::MASK_HIGH_LSB +: 8],
            cause_low & ~mask_reg[irq_ack_pkg::MASK_LOW_LSB +: 8]};
        win_idx = '0;
        for (int g = 0; g < irq_ack_pkg::GROUPS; g++)
            grp_active[g] = |pend[g*irq_ack_pkg::GRP_SIZE +: irq_ack_pkg::GRP_SIZE];
        for (int g = irq_ack_pkg::GROUPS - 1; g >= 0; g--)
            if (grp_active[g])
                win_idx = 3'(g);
        grp_clr_mask = '0;
        if (complete)
            grp_clr_mask[grp_reg*irq_ack_pkg::GRP_SIZE +: irq_ack_pkg::GRP_SIZE] = '1;
        pend_after = pend & ~grp_clr_mask;
    end
    assign any_pend = |pend;

    // Acknowledge cycle detect; single strobe needs the data strobe too
    assign ack_active = !VECTOR_FETCH_STROBE_N && (two_cycle || !BUS_STROBE_N);
    assign ack_rise = ack_active && !fetch_prev_reg;
    assign ack_fall = !ack_active && fetch_prev_reg;
    assign addr_match = {CHAIN_ENABLE_IN, CHAIN_ENABLE_OUT_I} == slave_addr;
    assign accept_ok = req_reg && (daisy ? CHAIN_ENABLE_IN : addr_match);
    assign in_service = state_reg != irq_ack_pkg::ACK_IDLE;

    // Acknowledge sequence
    always_comb
    begin
        state_next = state_reg;
        complete = 1'b0;
        fetch_prev_next = ack_active;
        unique case (state_reg)
            irq_ack_pkg::ACK_IDLE:
                if (ack_rise && accept_ok)
                    state_next = irq_ack_pkg::ACK_FIRST;
            irq_ack_pkg::ACK_FIRST:
                if (ack_fall)
                begin
                    state_next = two_cycle ? irq_ack_pkg::ACK_GAP : irq_ack_pkg::ACK_IDLE;
                    complete = !two_cycle;
                end
            irq_ack_pkg::ACK_GAP:
                if (ack_rise)
                    state_next = irq_ack_pkg::ACK_SECOND;
            irq_ack_pkg::ACK_SECOND:
                if (ack_fall)
                begin
                    state_next = irq_ack_pkg::ACK_IDLE;
                    complete = 1'b1;
                end
        endcase
        // Chain enable lost mid-sequence aborts without servicing
        if (daisy && !CHAIN_ENABLE_IN && in_service)
        begin
            state_next = irq_ack_pkg::ACK_IDLE;
            complete = 1'b0;
        end
    end

    // Request: hold-off covers the cycle and the gap of the two-cycle style
    assign holdoff = ack_active || state_reg == irq_ack_pkg::ACK_GAP;
    always_comb
    begin
        if (daisy && !CHAIN_ENABLE_IN)
            req_next = 1'b0;
        else if (complete)
            req_next = |pend_after;
        else if (!any_pend)
            req_next = 1'b0;
        else if (req_reg)
            req_next = 1'b1;
        else
            req_next = !holdoff;
    end

    // Vector latched at acceptance so it stays stable for the cycle
    always_comb
    begin
        vec_next = vec_reg;
        grp_next = grp_reg;
        if (state_reg == irq_ack_pkg::ACK_IDLE && state_next == irq_ack_pkg::ACK_FIRST)
        begin
            grp_next = win_idx;
            vec_next = {config_reg[irq_ack_pkg::CFG_VBASE_LSB + irq_ack_pkg::GRP_W +: 5], win_idx};
        end
    end

    // Transfer ack: host cycles exclude acknowledge, select is idle then
    assign reg_cycle = !CHIP_SELECT_N && VECTOR_FETCH_STROBE_N &&
        (!BUS_STROBE_N || (two_cycle && !WRITE_N));
    assign tack_cond = reg_cycle || (ack_active && (state_reg == irq_ack_pkg::ACK_FIRST ||
        state_reg == irq_ack_pkg::ACK_SECOND));
    assign tack_next = tack_cond;
    assign TRANSFER_ACK_OUT_N = 1'b0;
    assign TRANSFER_ACK_OUT_OE = tack_reg && tack_cond;

    // Vector drive, second cycle only in the two-cycle style
    assign DATA_O = vec_reg;
    assign DATA_OE = ack_active && (two_cycle ? state_reg == irq_ack_pkg::ACK_SECOND :
        state_reg == irq_ack_pkg::ACK_FIRST && !BUS_STROBE_N);

    // Request pin style; code 3 is unused and falls back to active low
    always_comb
    begin
        SERVICE_REQ_O = 1'b0;
        SERVICE_REQ_OE = 1'b1;
        unique case (port_style)
            irq_ack_pkg::PORT_PP_HIGH: SERVICE_REQ_O = req_reg;
            irq_ack_pkg::PORT_OPEN_DRAIN: SERVICE_REQ_OE = req_reg;
            default: SERVICE_REQ_O = !req_reg;
        endcase
    end

    // Chain out: combinational so lower devices block at once
    assign CHAIN_ENABLE_OUT_O = CHAIN_ENABLE_IN && !req_reg;
    assign CHAIN_ENABLE_OUT_OE = daisy;

    // Register writes in the access phase, read data capture in the setup phase
    always_comb
    begin
        config_next = config_reg;
        mask_next = mask_reg;
        prdata_next = prdata_reg;
        if (wr_en && PADDR == irq_ack_pkg::CONFIG_OFFSET)
            config_next = PWDATA & irq_ack_pkg::CONFIG_WMASK;
        if (wr_en && PADDR == irq_ack_pkg::MASK_OFFSET)
            mask_next = PWDATA & irq_ack_pkg::MASK_WMASK;
        if (rd_setup)
        begin
            prdata_next = '0;
            unique case (PADDR)
                irq_ack_pkg::CONFIG_OFFSET: prdata_next = config_reg;
                irq_ack_pkg::MASK_OFFSET: prdata_next = mask_reg;
                irq_ack_pkg::CAUSE_LOW_OFFSET: prdata_next[7:0] = cause_low;
                irq_ack_pkg::CAUSE_HIGH_OFFSET: prdata_next[7:0] = cause_high;
                irq_ack_pkg::PP_CAUSE_OFFSET: prdata_next[7:0] = cause_pp;
                irq_ack_pkg::SUMMARY_OFFSET:
                begin
                    prdata_next[2:0] = {|cause_pp, |cause_high, |cause_low};
                    prdata_next[irq_ack_pkg::SUM_REQ_BIT] = req_reg;
                    prdata_next[irq_ack_pkg::SUM_GRP_LSB +: 3] = grp_reg;
                end
                default: prdata_next = '0;
            endcase
        end
    end

    // Register stage for all state
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            config_reg <= irq_ack_pkg::CONFIG_RESET;
            mask_reg <= irq_ack_pkg::MASK_RESET;
            prdata_reg <= '0;
            req_reg <= 1'b0;
            tack_reg <= 1'b0;
            fetch_prev_reg <= 1'b0;
            vec_reg <= '0;
            grp_reg <= '0;
            state_reg <= irq_ack_pkg::ACK_IDLE;
        end
        else
        begin
            config_reg <= config_next;
            mask_reg <= mask_next;
            prdata_reg <= prdata_next;
            req_reg <= req_next;
            tack_reg <= tack_next;
            fetch_prev_reg <= fetch_prev_next;
            vec_reg <= vec_next;
            grp_reg <= grp_next;
            state_reg <= state_next;
        end
    end

    // Checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);

    a_tack_assert: assert property (tack_cond [*2] |-> TRANSFER_ACK_OUT_OE)
        else $error("transfer ack missing in held cycle");
    a_tack_release: assert property (VECTOR_FETCH_STROBE_N && (CHIP_SELECT_N ||
        (BUS_STROBE_N && (WRITE_N || !two_cycle))) |-> !TRANSFER_ACK_OUT_OE)
        else $error("transfer ack held after cycle end");
    a_req_open_drain: assert property (port_style == irq_ack_pkg::PORT_OPEN_DRAIN |->
        !SERVICE_REQ_O && SERVICE_REQ_OE == req_reg)
        else $error("open drain request style wrong");
    a_daisy_gate: assert property (daisy && !CHAIN_ENABLE_IN |=> !req_reg)
        else $error("request raised without chain enable");
    a_idle_drop: assert property (!any_pend && !complete |=> !req_reg)
        else $error("request with nothing pending");
    a_chain_block: assert property (req_reg |-> !CHAIN_ENABLE_OUT_O)
        else $error("chain out high while requesting");
    a_vector_group: assert property (state_reg == irq_ack_pkg::ACK_IDLE && state_next ==
        irq_ack_pkg::ACK_FIRST |=> vec_reg[2:0] == $past(win_idx))
        else $error("vector not the winning group");
    a_vector_stable: assert property (in_service && $past(in_service) |-> $stable(vec_reg))
        else $error("vector changed during acknowledge");
    a_slave_refuse: assert property (!daisy && ack_rise && !addr_match && !in_service
        |=> state_reg == irq_ack_pkg::ACK_IDLE)
        else $error("acknowledge taken on address mismatch");
    a_hold_off: assert property (!req_reg && holdoff && !(daisy && !CHAIN_ENABLE_IN) |=> !req_reg)
        else $error("request started during acknowledge");
    a_vector_drive: assert property (DATA_OE |-> ack_active && in_service)
        else $error("vector driven outside acknowledge");

    c_single_ack: cover property (!two_cycle && state_reg == irq_ack_pkg::ACK_FIRST ##[1:20] complete);
    c_two_cycle_ack: cover property (state_reg == irq_ack_pkg::ACK_SECOND ##[1:20] complete);
    c_daisy_abort: cover property (daisy && in_service ##1 !CHAIN_ENABLE_IN);
    c_reg_tack: cover property (reg_cycle ##1 TRANSFER_ACK_OUT_OE);

endmodule // irq_ack_ctrl
`default_nettype wire

// ---- logic/irq_ack_pkg.sv ----
// Constants, register map and types for the interrupt request and acknowledge block
package irq_ack_pkg;

    // APB register byte offsets
    localparam logic [7:0] CONFIG_OFFSET = 8'h00;
    localparam logic [7:0] MASK_OFFSET = 8'h04;
    localparam logic [7:0] CAUSE_LOW_OFFSET = 8'h08;
    localparam logic [7:0] CAUSE_HIGH_OFFSET = 8'h0C;
    localparam logic [7:0] PP_CAUSE_OFFSET = 8'h10;
    localparam logic [7:0] SUMMARY_OFFSET = 8'h14;

    // Config register fields
    localparam int CFG_BUS_STYLE_BIT = 0;
    localparam int CFG_DAISY_BIT = 1;
    localparam int CFG_PORT_LSB = 2;
    localparam int CFG_SLAVE_LSB = 4;
    localparam int CFG_PP_EN_BIT = 6;
    localparam int CFG_VBASE_LSB = 8;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] CONFIG_WMASK = 32'h0000_FF7F;

    // Mask register fields, a set bit blocks the source
    localparam int MASK_LOW_LSB = 0;
    localparam int MASK_HIGH_LSB = 8;
    localparam int MASK_PP_LSB = 16;
    localparam logic [31:0] MASK_RESET = 32'h00FF_FFFF;
    localparam logic [31:0] MASK_WMASK = 32'h00FF_FFFF;

    // Summary register fields
    localparam int SUM_REQ_BIT = 3;
    localparam int SUM_GRP_LSB = 8;

    // Source and group geometry
    localparam int BANK_W = 8;
    localparam int SRC_W = 24;
    localparam int GROUPS = 8;
    localparam int GRP_W = 3;
    localparam int GRP_SIZE = 3;
    localparam int VEC_W = 8;

    // Request pin electrical style
    typedef enum logic [1:0]
    {
        PORT_PP_LOW = 2'h0,
        PORT_PP_HIGH = 2'h1,
        PORT_OPEN_DRAIN = 2'h2
    } port_style_t;

    // Acknowledge sequence, Gray coded along the two-cycle path
    typedef enum logic [1:0]
    {
        ACK_IDLE = 2'b00,
        ACK_FIRST = 2'b01,
        ACK_GAP = 2'b11,
        ACK_SECOND = 2'b10
    } ack_state_t;

endpackage
